//--- core/ppr_consts.vh
// constants of the printer port register logic
`ifndef PPR_CONSTS_VH
`define PPR_CONSTS_VH

// register offsets on the two address lines
`define PPR_OFS_DATA_PORT    2'h0
`define PPR_OFS_STATUS       2'h1
`define PPR_OFS_DIR_CODE     2'h1
`define PPR_OFS_PIN_DRIVE    2'h2
`define PPR_OFS_PIN_READBACK 2'h2

// pin drive and readback field positions
`define PPR_BIT_LATCH        0
`define PPR_BIT_AUTOFEED     1
`define PPR_BIT_INIT         2
`define PPR_BIT_SELECT       3
`define PPR_BIT_IRQ_EN       4
`define PPR_BIT_DIR          5

// status field positions
`define PPR_BIT_IRQ_STAT     2
`define PPR_BIT_FAULT        3
`define PPR_BIT_ONLINE       4
`define PPR_BIT_PAPER        5
`define PPR_BIT_ACK          6
`define PPR_BIT_BUSY         7

// direction codes
`define PPR_DIR_CODE_IN      8'haa
`define PPR_DIR_CODE_OUT     8'h55

// reset values
`define PPR_RST_CTRL         6'h00
`define PPR_RST_DATA         8'h00
`define PPR_RST_IRQ_STAT     1'b1
`define PPR_UNMAPPED_READ    8'hff

// fifo geometry
`define PPR_FIFO_WIDTH       8
`define PPR_FIFO_DEPTH       4
`define PPR_FIFO_AW          2

`endif

//--- core/ppr_fifo.v
// small valid/ready fifo for bytes bound to the data pins
`timescale 1ns/10ps
`default_nettype none
module ppr_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // clock and reset
    input  wire             core_clk,
    input  wire             rst,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_ff;
    reg [AW-1:0]    rd_ptr_ff;
    reg [AW:0]      count_ff;
    wire            push;
    wire            pop;

    assign in_ready  = (count_ff != DEPTH[AW:0]);
    assign out_valid = (count_ff != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_ff];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push & ~pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop & ~push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule // ppr_fifo
`default_nettype wire

//--- core/ppr_sync.v
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
`default_nettype none
module ppr_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         core_clk,
    input  wire         rst,
    // pins in, synchronised out
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    always @(posedge core_clk) begin
        if (rst) begin
            meta_ff <= {W{1'b1}};
            sync_ff <= {W{1'b1}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // ppr_sync
`default_nettype wire

//--- core/ppr_top.v
// printer port register logic: host strobes, registers and pin drive
// Notes on behaviour
// RL1 - in output direction a data port write reaches the eight data pins
// RL2 - in input direction a data port read returns the sampled pin levels
// RL3 - after reset the data pins drive out, all eight low; with BIDIR_CAPABLE 0 they follow the mode pin, high meaning input
// RL4 - status bits 1..0 and readback bits 7..5 always read one
// RL5 - ack falling edge clears status bit 2, marking a pending interrupt
// RL6 - a status read sets bit 2 back to one, withdrawing the request
// RL7 - status bits 3..6 show fault, online, paper out, ack levels uninverted
// RL8 - status bit 7 shows busy inverted
// RL9 - readback shows actual handshake pin states and enable in any direction
// RL10 - readback bits 0,1,3 one when pin low; bit 2 one when init high
// RL11 - readback bit 4 shows the interrupt enable setting
// RL12 - drive bits 0,1,3 one pull pin low; bit 2 one drives init high
// RL13 - drive bit 4 enables the printer interrupt output
// RL14 - mode pin high: drive bit 5 selects direction, one meaning input
// RL15 - mode pin low: code aa selects input, 55 selects output
// RL16 - direction code and drive bit 5 exist only in the bidirectional variant
// RL17 - reset drives latch, autofeed, select high and init low, outputs
// RL18 - interrupt output asserted only while pending and enabled
`timescale 1ns/10ps
`default_nettype none
`include "ppr_consts.vh"
module ppr_top #(
    parameter BIDIR_CAPABLE = 1
) (
    // clock and reset
    input  wire       core_clk,
    input  wire       rst,
    // host register port
    input  wire       host_cs_n,
    input  wire       host_rd_n,
    input  wire       host_wr_n,
    input  wire [1:0] host_addr,
    input  wire [7:0] host_data_in,
    output wire [7:0] host_data_out,
    output wire       host_data_oe,
    // direction mode strap
    input  wire       direction_mode_pin,
    // printer inputs
    input  wire       fault_n,
    input  wire       printer_online,
    input  wire       paper_out,
    input  wire       ack_n,
    input  wire       busy,
    // parallel data pins
    input  wire [7:0] parallel_data_pins_in,
    output wire [7:0] parallel_data_pins_out,
    output wire       parallel_data_pins_oe,
    // handshake outputs
    output wire       byte_latch_n,
    output wire       auto_line_feed_n,
    output wire       init_out,
    output wire       printer_select_n,
    // interrupt and flow
    output wire       printer_irq_out,
    output wire       data_fifo_ready
);
    localparam SW = 27;

    // synchronised pins
    wire [SW-1:0] raw_in;
    wire [SW-1:0] syn;
    wire          s_cs_n;
    wire          s_rd_n;
    wire          s_wr_n;
    wire [1:0]    s_addr;
    wire [7:0]    s_data;
    wire          s_mode;
    wire          s_fault_n;
    wire          s_online;
    wire          s_paper;
    wire          s_ack_n;
    wire          s_busy;
    wire [7:0]    s_pins;

    assign raw_in = {host_cs_n, host_rd_n, host_wr_n, host_addr,
                     host_data_in, direction_mode_pin, fault_n,
                     printer_online, paper_out, ack_n, busy,
                     parallel_data_pins_in};

    ppr_sync #(
        .W(SW)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (raw_in),
        .sync_out (syn)
    );

    assign s_cs_n    = syn[26];
    assign s_rd_n    = syn[25];
    assign s_wr_n    = syn[24];
    assign s_addr    = syn[23:22];
    assign s_data    = syn[21:14];
    assign s_mode    = syn[13];
    assign s_fault_n = syn[12];
    assign s_online  = syn[11];
    assign s_paper   = syn[10];
    assign s_ack_n   = syn[9];
    assign s_busy    = syn[8];
    assign s_pins    = syn[7:0];

    // state
    reg       rd_act_ff;
    reg       wr_act_ff;
    reg [1:0] wr_addr_ff;
    reg [7:0] wr_data_ff;
    reg       ack_prev_ff;
    reg [5:0] ctrl_ff;
    reg       code_in_ff;
    reg       irq_stat_ff;
    reg [7:0] host_dout_ff;
    reg       host_oe_ff;
    reg [7:0] pd_out_ff;
    reg       pd_oe_ff;
    reg       latch_n_ff;
    reg       afd_n_ff;
    reg       init_ff;
    reg       sel_n_ff;
    reg       irq_ff;
    reg       fifo_rdy_ff;

    // strobe decode
    wire rd_act;
    wire wr_act;
    wire rd_start;
    wire wr_done;

    assign rd_act   = ~s_cs_n & ~s_rd_n;
    assign wr_act   = ~s_cs_n & ~s_wr_n;
    assign rd_start = rd_act & ~rd_act_ff;
    assign wr_done  = wr_act_ff & ~wr_act;

    function is_sel;
        input [1:0] a;
        input [1:0] ofs;
        begin
            is_sel = (a == ofs);
        end
    endfunction

    wire wr_data_port;
    wire wr_dir_code;
    wire wr_ctrl;
    wire rd_status;

    assign wr_data_port = wr_done & is_sel(wr_addr_ff, `PPR_OFS_DATA_PORT);
    assign wr_dir_code  = wr_done & is_sel(wr_addr_ff, `PPR_OFS_DIR_CODE);
    assign wr_ctrl      = wr_done & is_sel(wr_addr_ff, `PPR_OFS_PIN_DRIVE);
    assign rd_status    = rd_start & is_sel(s_addr, `PPR_OFS_STATUS);

    // direction selection
    reg nxt_dir_in;

    always @* begin
        if (BIDIR_CAPABLE == 0) begin
            nxt_dir_in = s_mode; // RL16
        end else if (s_mode) begin
            nxt_dir_in = ctrl_ff[`PPR_BIT_DIR]; // RL14
        end else begin
            nxt_dir_in = code_in_ff; // RL15
        end
    end

    // byte fifo toward the data pins
    wire       f_in_ready;
    wire       f_out_valid;
    wire [7:0] f_out_data;
    wire       f_drain;

    assign f_drain = ~nxt_dir_in;

    ppr_fifo #(
        .WIDTH(`PPR_FIFO_WIDTH),
        .DEPTH(`PPR_FIFO_DEPTH),
        .AW   (`PPR_FIFO_AW)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (wr_data_port),
        .in_ready  (f_in_ready),
        .in_data   (wr_data_ff),
        .out_valid (f_out_valid),
        .out_ready (f_drain),
        .out_data  (f_out_data)
    );

    // read data mux
    wire [7:0] status_val;
    wire [7:0] readback_val;
    reg  [7:0] nxt_host_dout;

    assign status_val = {~s_busy, s_ack_n, s_paper, s_online, // RL7 RL8
                         s_fault_n, irq_stat_ff, 2'b11}; // RL4
    assign readback_val = {3'b111, ctrl_ff[`PPR_BIT_IRQ_EN], // RL4 RL11
                           ~sel_n_ff, init_ff, ~afd_n_ff, // RL9 RL10
                           ~latch_n_ff}; // RL10

    always @* begin
        case (s_addr)
            `PPR_OFS_DATA_PORT: begin
                if (pd_oe_ff) begin
                    nxt_host_dout = pd_out_ff;
                end else begin
                    nxt_host_dout = s_pins; // RL2
                end
            end
            `PPR_OFS_STATUS: begin
                nxt_host_dout = status_val;
            end
            `PPR_OFS_PIN_READBACK: begin
                nxt_host_dout = readback_val;
            end
            default: begin
                nxt_host_dout = `PPR_UNMAPPED_READ;
            end
        endcase
    end

    // strobe tracking and write capture
    always @(posedge core_clk) begin
        if (rst) begin
            rd_act_ff   <= 1'b0;
            wr_act_ff   <= 1'b0;
            wr_addr_ff  <= 2'h0;
            wr_data_ff  <= `PPR_RST_DATA;
            ack_prev_ff <= 1'b1;
        end else begin
            rd_act_ff   <= rd_act;
            wr_act_ff   <= wr_act;
            ack_prev_ff <= s_ack_n;
            if (wr_act) begin
                wr_addr_ff <= s_addr;
                wr_data_ff <= s_data;
            end
        end
    end

    // registers written by the host
    always @(posedge core_clk) begin
        if (rst) begin
            ctrl_ff    <= `PPR_RST_CTRL;
            code_in_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= wr_data_ff[5:0];
                if (BIDIR_CAPABLE == 0) begin
                    ctrl_ff[`PPR_BIT_DIR] <= 1'b0; // RL16
                end
            end
            if (wr_dir_code && BIDIR_CAPABLE != 0) begin
                if (wr_data_ff == `PPR_DIR_CODE_IN) begin
                    code_in_ff <= 1'b1; // RL15
                end else if (wr_data_ff == `PPR_DIR_CODE_OUT) begin
                    code_in_ff <= 1'b0; // RL15
                end
            end
        end
    end

    // interrupt status, edge wins over read clear
    always @(posedge core_clk) begin
        if (rst) begin
            irq_stat_ff <= `PPR_RST_IRQ_STAT;
        end else if (ack_prev_ff & ~s_ack_n) begin
            irq_stat_ff <= 1'b0; // RL5
        end else if (rd_status) begin
            irq_stat_ff <= 1'b1; // RL6
        end
    end

    // pin and host outputs
    always @(posedge core_clk) begin
        if (rst) begin
            pd_out_ff    <= `PPR_RST_DATA; // RL3
            pd_oe_ff     <= 1'b1; // RL3
            latch_n_ff   <= 1'b1; // RL17
            afd_n_ff     <= 1'b1; // RL17
            init_ff      <= 1'b0; // RL17
            sel_n_ff     <= 1'b1; // RL17
            irq_ff       <= 1'b0;
            host_dout_ff <= `PPR_UNMAPPED_READ;
            host_oe_ff   <= 1'b0;
            fifo_rdy_ff  <= 1'b0;
        end else begin
            pd_oe_ff <= ~nxt_dir_in; // RL14 RL15
            if (f_out_valid & f_drain) begin
                pd_out_ff <= f_out_data; // RL1
            end
            latch_n_ff <= ~ctrl_ff[`PPR_BIT_LATCH]; // RL12
            afd_n_ff   <= ~ctrl_ff[`PPR_BIT_AUTOFEED]; // RL12
            init_ff    <= ctrl_ff[`PPR_BIT_INIT]; // RL12
            sel_n_ff   <= ~ctrl_ff[`PPR_BIT_SELECT]; // RL12
            irq_ff     <= ~irq_stat_ff & ctrl_ff[`PPR_BIT_IRQ_EN]; // RL13 RL18
            host_oe_ff <= rd_act;
            // snapshot at read start, before the status clear lands
            if (rd_start) begin
                host_dout_ff <= nxt_host_dout; // RL5
            end
            fifo_rdy_ff <= f_in_ready;
        end
    end

    assign host_data_out          = host_dout_ff;
    assign host_data_oe           = host_oe_ff;
    assign parallel_data_pins_out = pd_out_ff;
    assign parallel_data_pins_oe  = pd_oe_ff;
    assign byte_latch_n           = latch_n_ff;
    assign auto_line_feed_n       = afd_n_ff;
    assign init_out               = init_ff;
    assign printer_select_n       = sel_n_ff;
    assign printer_irq_out        = irq_ff;
    assign data_fifo_ready        = fifo_rdy_ff;
endmodule // ppr_top
`default_nettype wire

//--- dv/ppr_checker.sv
// assertion checker on the ports of the printer port register logic
`timescale 1ns/10ps
`default_nettype none
module ppr_checker (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst,
    // host port
    input wire logic       host_cs_n,
    input wire logic       host_rd_n,
    input wire logic       host_wr_n,
    input wire logic [1:0] host_addr,
    input wire logic [7:0] host_data_out,
    input wire logic       host_data_oe,
    // printer lines
    input wire logic       fault_n,
    input wire logic       printer_online,
    input wire logic       paper_out,
    input wire logic       ack_n,
    input wire logic       busy,
    // pins and flow
    input wire logic [7:0] parallel_data_pins_out,
    input wire logic       parallel_data_pins_oe,
    input wire logic       byte_latch_n,
    input wire logic       auto_line_feed_n,
    input wire logic       init_out,
    input wire logic       printer_select_n,
    input wire logic       printer_irq_out,
    input wire logic       data_fifo_ready
);
    logic [4:0] pr_in;
    logic [3:0] hs;
    logic       rd_cmd;
    logic       rd_st;
    logic       rd_rb;
    logic [7:0] wr_hist_ff;
    assign pr_in = {~busy, ack_n, paper_out, printer_online, fault_n};
    assign hs = {printer_select_n, init_out, auto_line_feed_n, byte_latch_n};
    assign rd_cmd = !host_cs_n && !host_rd_n && host_addr == 2'h1;
    assign rd_st = rd_cmd && host_data_oe;
    assign rd_rb = host_data_oe && !host_cs_n && !host_rd_n
                   && host_addr == 2'h2;
    // recent write strobes
    always_ff @(posedge core_clk) begin
        if (rst)
            wr_hist_ff <= 8'h00;
        else
            wr_hist_ff <= {wr_hist_ff[6:0], !host_cs_n && !host_wr_n};
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_status_ones: assert property (
        rd_st |-> host_data_out[1:0] == 2'b11)
        else $error("status spare bits not one");
    a_rb_ones: assert property (
        rd_rb |-> host_data_out[7:5] == 3'b111)
        else $error("readback spare bits not one");
    a_rb_pins: assert property (
        rd_rb |-> host_data_out[3:0] == (~hs ^ 4'h4))
        else $error("readback disagrees with pins");
    a_status_live: assert property (
        $stable(pr_in) [*6] ##0 rd_st |-> host_data_out[7:3] == pr_in)
        else $error("status disagrees with printer lines");
    a_irq_withdrawn: assert property (
        $stable(ack_n) [*3] ##1 (rd_cmd && $stable(ack_n)) [*6]
        |-> !printer_irq_out)
        else $error("interrupt kept through status read");
    a_reset_pins: assert property (
        $fell(rst) |-> parallel_data_pins_oe
        && parallel_data_pins_out == 8'h00 && hs == 4'hb && !printer_irq_out)
        else $error("pins not at reset state");
    a_pins_by_write: assert property ($changed(hs) |-> |wr_hist_ff)
        else $error("handshake pin moved without a write");
    a_oe_after_rd: assert property (
        $rose(host_data_oe) |-> !host_cs_n && !host_rd_n
        && $past(host_rd_n, 2) == 1'b0)
        else $error("read data driven without a read");
    c_status_read: cover property (rd_st);
    c_irq_raised: cover property ($rose(printer_irq_out));
    c_fifo_full: cover property ($fell(data_fifo_ready));
    c_input_dir: cover property ($fell(parallel_data_pins_oe));
endmodule // ppr_checker
bind ppr_top ppr_checker u_chk (.core_clk, .rst, .host_cs_n, .host_rd_n,
    .host_wr_n, .host_addr, .host_data_out, .host_data_oe, .fault_n,
    .printer_online, .paper_out, .ack_n, .busy, .parallel_data_pins_out,
    .parallel_data_pins_oe, .byte_latch_n, .auto_line_feed_n, .init_out,
    .printer_select_n, .printer_irq_out, .data_fifo_ready);
`default_nettype wire

//--- dv/ppr_printer_model.sv
// printer model: status lines and its side of the data pins
`timescale 1ns/10ps
`default_nettype none
module ppr_printer_model (
    // clock
    input  wire logic       core_clk,
    // data pins
    input  wire logic [7:0] pins_out,
    input  wire logic       pins_oe,
    output var  logic [7:0] pins_in,
    // status lines
    output var  logic       fault_n,
    output var  logic       printer_online,
    output var  logic       paper_out,
    output var  logic       ack_n,
    output var  logic       busy
);
    logic [7:0] drv_ff = 8'h00;
    // printer drives the pins only while the port does not
    always_comb pins_in = pins_oe ? pins_out : drv_ff;
    initial begin
        {busy, ack_n, paper_out, printer_online, fault_n} = 5'h0b;
    end
    task automatic set_lines(input logic [4:0] v);
        @(posedge core_clk);
        {busy, ack_n, paper_out, printer_online, fault_n} <= v;
    endtask
    task automatic set_data(input logic [7:0] v);
        @(posedge core_clk);
        drv_ff <= v;
    endtask
    task automatic ack_pulse;
        @(posedge core_clk);
        ack_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        ack_n <= 1'b1;
    endtask
endmodule // ppr_printer_model
`default_nettype wire

//--- dv/ppr_top_tb.sv
// self-checking bench for the printer port register logic
`timescale 1ns/10ps
`default_nettype none
module ppr_top_tb;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       host_cs_n = 1'b1;
    logic       host_rd_n = 1'b1;
    logic       host_wr_n = 1'b1;
    logic [1:0] host_addr = 2'h0;
    logic [7:0] host_data_in = 8'h00;
    logic       direction_mode_pin = 1'b1;
    logic [7:0] host_data_out, parallel_data_pins_in, parallel_data_pins_out;
    logic       host_data_oe, fault_n, printer_online, paper_out, ack_n;
    logic       busy, parallel_data_pins_oe, byte_latch_n, auto_line_feed_n;
    logic       init_out, printer_select_n, printer_irq_out, data_fifo_ready;
    logic [7:0] d;
    logic [4:0] pat [4] = '{5'h08, 5'h1f, 5'h0a, 5'h1d};
    int         error_cnt = 0;
    int         compares = 0;
    always #50 core_clk = ~core_clk;
    ppr_top #(.BIDIR_CAPABLE(1)) u_dut (.core_clk, .rst, .host_cs_n,
        .host_rd_n, .host_wr_n, .host_addr, .host_data_in, .host_data_out,
        .host_data_oe, .direction_mode_pin, .fault_n, .printer_online,
        .paper_out, .ack_n, .busy, .parallel_data_pins_in,
        .parallel_data_pins_out, .parallel_data_pins_oe, .byte_latch_n,
        .auto_line_feed_n, .init_out, .printer_select_n, .printer_irq_out,
        .data_fifo_ready);
    ppr_printer_model u_prn (.core_clk, .pins_out(parallel_data_pins_out),
        .pins_oe(parallel_data_pins_oe), .pins_in(parallel_data_pins_in),
        .fault_n, .printer_online, .paper_out, .ack_n, .busy);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge core_clk);
        host_cs_n <= 1'b0;
        host_wr_n <= 1'b0;
        host_addr <= a;
        host_data_in <= v;
        cycles(4);
        host_cs_n <= 1'b1;
        host_wr_n <= 1'b1;
        cycles(8);
        #1;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge core_clk);
        host_cs_n <= 1'b0;
        host_rd_n <= 1'b0;
        host_addr <= a;
        cycles(6);
        #1 v = host_data_out;
        cycles(1);
        host_cs_n <= 1'b1;
        host_rd_n <= 1'b1;
        cycles(8);
        #1;
    endtask
    task automatic chk_rst;
        chk({parallel_data_pins_oe, init_out, printer_irq_out, byte_latch_n,
             auto_line_feed_n, printer_select_n, host_data_oe, 1'b0},
            8'h9c);
        chk(parallel_data_pins_out, 8'h00);
        chk(host_data_out, 8'hff);
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        cycles(5000);
        error_cnt++;
        stop_test();
    end
    initial begin
        cycles(6);
        rst <= 1'b0;
        cycles(1);
        #1 chk_rst();
        rd(2'h2, d);
        chk(d, 8'he0);
        rd(2'h1, d);
        chk(d, 8'hdf);
        $display("test reset done");
        foreach (pat[k]) begin
            u_prn.set_lines(pat[k]);
            rd(2'h1, d);
            chk(d, {~pat[k][4], pat[k][3:0], 3'b111});
        end
        u_prn.set_lines(5'h0b);
        $display("test status done");
        for (int i = 0; i < 16; i++) begin
            wr(2'h2, {3'b000, i[0], i[3:0]});
            rd(2'h2, d);
            chk(d, {3'b111, i[0], i[3:0]});
            chk({4'h0, printer_select_n, init_out, auto_line_feed_n,
                 byte_latch_n}, {4'h0, ~i[3], i[2], ~i[1], ~i[0]});
        end
        $display("test pin drive done");
        wr(2'h2, 8'h00);
        u_prn.ack_pulse();
        cycles(6);
        chk({7'h0, printer_irq_out}, 8'h00);
        wr(2'h2, 8'h10);
        chk({7'h0, printer_irq_out}, 8'h01);
        rd(2'h1, d);
        chk({7'h0, printer_irq_out}, 8'h00);
        chk(d, 8'hdb);
        rd(2'h1, d);
        chk(d, 8'hdf);
        u_prn.ack_pulse();
        cycles(6);
        chk({7'h0, printer_irq_out}, 8'h01);
        wr(2'h2, 8'h00);
        chk({7'h0, printer_irq_out}, 8'h00);
        rd(2'h1, d);
        chk(d, 8'hdb);
        $display("test interrupt done");
        wr(2'h0, 8'ha5);
        chk(parallel_data_pins_out, 8'ha5);
        rd(2'h0, d);
        chk(d, 8'ha5);
        wr(2'h2, 8'h20);
        chk({7'h0, parallel_data_pins_oe}, 8'h00);
        u_prn.set_data(8'h3c);
        rd(2'h0, d);
        chk(d, 8'h3c);
        rd(2'h2, d);
        chk(d, 8'he0);
        for (int k = 0; k < 5; k++)
            wr(2'h0, 8'h10 + k[7:0]);
        chk({7'h0, data_fifo_ready}, 8'h00);
        wr(2'h2, 8'h00);
        cycles(4);
        chk(parallel_data_pins_out, 8'h13);
        chk({7'h0, data_fifo_ready}, 8'h01);
        $display("test data path done");
        @(posedge core_clk);
        direction_mode_pin <= 1'b0;
        wr(2'h1, 8'haa);
        chk({7'h0, parallel_data_pins_oe}, 8'h00);
        wr(2'h1, 8'h12);
        chk({7'h0, parallel_data_pins_oe}, 8'h00);
        wr(2'h1, 8'h55);
        chk({7'h0, parallel_data_pins_oe}, 8'h01);
        wr(2'h2, 8'h20);
        chk({7'h0, parallel_data_pins_oe}, 8'h01);
        rd(2'h3, d);
        chk(d, 8'hff);
        $display("test direction code done");
        wr(2'h2, 8'h0f);
        @(posedge core_clk);
        rst <= 1'b1;
        cycles(3);
        rst <= 1'b0;
        cycles(1);
        #1 chk_rst();
        $display("test second reset done");
        stop_test();
    end
endmodule // ppr_top_tb
`default_nettype wire
